// *** verilog/dsmc_top.sv ***
// Purpose: Command-side pattern access, gear-down and deep power-down control.
// Assumes: Command pins are sampled on CLOCK; the controller keeps its timing.
// Notes:   Array commands are forwarded, pattern accesses stay inside.
`timescale 1ns/1ps
`default_nettype none
`include "dsmc_regs.svh"
module dsmc_top #(
  parameter logic [31:0] PATTERN_INIT = `DSMC_PATTERN_RESET
) (
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST,
  input  wire logic        RESET_N,
  // Command and address pins
  input  wire logic        CKE,
  input  wire logic        CS_N,
  input  wire logic        ACT_N,
  input  wire logic        RAS_N,
  input  wire logic        CAS_N,
  input  wire logic        WE_N,
  input  wire logic [1:0]  BG,
  input  wire logic [1:0]  BA,
  input  wire logic [17:0] ADDR,
  // Mode status
  output var  logic        PATTERN_MODE,
  output var  logic        GEAR_DOWN,
  output var  logic        SELF_REFRESH,
  output var  logic        DEEP_POWER_DOWN,
  output var  logic        INPUTS_ENABLED,
  // Commands forwarded to the array, and command rejects
  output var  logic        ARRAY_CMD_VALID,
  output var  logic [3:0]  ARRAY_CMD,
  output var  logic        CMD_REJECT,
  // Pattern read data
  output var  logic        RD_VALID,
  output var  logic        RD_CHOP,
  output logic [7:0]       RD_DATA
);
  localparam logic [7:0] MOD_CYC   = 8'(`DSMC_MOD_CYC);
  localparam logic [7:0] ENTRY_CYC = 8'(`DSMC_DPD_ENTRY_CYC);
  localparam logic [7:0] GEAR_CYC  = 8'(`DSMC_GEAR_CMD_CYC);

  dsmc_store_if store_bus ();

  dsmc_pattern_store #(
    .PATTERN_INIT (PATTERN_INIT)
  ) u_store (
    .clk  (CLOCK),
    .rst  (RST || !RESET_N),
    .port (store_bus.store)
  );

  function automatic dsmc_pkg::dsmc_cmd_t decode(input logic cs_n, input logic act_n,
                                                 input logic ras_n, input logic cas_n,
                                                 input logic we_n);
    dsmc_pkg::dsmc_cmd_t c;
    c = dsmc_pkg::DSMC_CMD_DES;
    if (!cs_n) begin
      if (!act_n) begin
        c = dsmc_pkg::DSMC_CMD_ACT;
      end else begin
        unique case ({ras_n, cas_n, we_n})
          3'h0: c = dsmc_pkg::DSMC_CMD_MRS;
          3'h1: c = dsmc_pkg::DSMC_CMD_REF;
          3'h2: c = dsmc_pkg::DSMC_CMD_PRE;
          3'h3: c = dsmc_pkg::DSMC_CMD_ACT;
          3'h4: c = dsmc_pkg::DSMC_CMD_WR;
          3'h5: c = dsmc_pkg::DSMC_CMD_RD;
          3'h6: c = dsmc_pkg::DSMC_CMD_ZQ;
          3'h7: c = dsmc_pkg::DSMC_CMD_NOP;
        endcase
      end
    end
    return c;
  endfunction

  dsmc_pkg::dsmc_gear_t gear, next_gear;
  dsmc_pkg::dsmc_pwr_t  pwr, next_pwr;
  dsmc_pkg::dsmc_cmd_t  cmd;
  logic       pat_en, next_pat_en;
  logic [1:0] bl_mode, next_bl_mode;
  logic [2:0] fgr_mode, next_fgr_mode;
  logic       self_ref, next_self_ref;
  logic       phase, next_phase;
  logic       phase_ref, next_phase_ref;
  logic       cke_q, next_cke_q;
  logic [7:0] mod_cnt, next_mod_cnt;
  logic [7:0] gear_cnt, next_gear_cnt;
  logic [7:0] pwr_cnt, next_pwr_cnt;
  logic       next_array_valid, next_reject, next_rd_valid, next_rd_chop;
  logic [3:0] next_array_cmd;
  logic [2:0] mr_sel;
  logic       sample_ok;
  logic       live;

  assign mr_sel    = {BG[0], BA};
  assign live      = (pwr != dsmc_pkg::DSMC_PWR_DEEP) && !self_ref;
  assign sample_ok = (gear != dsmc_pkg::DSMC_GEAR_2N) || (phase == phase_ref);
  assign cmd       = (live && sample_ok) ? decode(CS_N, ACT_N, RAS_N, CAS_N, WE_N)
                                         : dsmc_pkg::DSMC_CMD_DES;

  always_comb begin
    next_gear        = gear;
    next_pwr         = pwr;
    next_pat_en      = pat_en;
    next_bl_mode     = bl_mode;
    next_fgr_mode    = fgr_mode;
    next_self_ref    = self_ref;
    next_phase       = !phase;
    next_phase_ref   = phase_ref;
    next_cke_q       = CKE;
    next_mod_cnt     = (mod_cnt != 8'h00) ? mod_cnt - 8'h01 : mod_cnt;
    next_gear_cnt    = gear_cnt + 8'h01;
    next_pwr_cnt     = pwr_cnt + 8'h01;
    next_array_valid = 1'b0;
    next_array_cmd   = 4'(cmd);
    next_reject      = 1'b0;
    next_rd_valid    = 1'b0;
    next_rd_chop     = RD_CHOP;
    store_bus.wr_en   = 1'b0;
    store_bus.wr_loc  = BA;
    store_bus.wr_data = ADDR[7:0];
    store_bus.rd_en   = 1'b0;
    store_bus.rd_loc  = BA;
    store_bus.rd_chop = (bl_mode == `DSMC_BL_CHOP);

    unique case (cmd)
      dsmc_pkg::DSMC_CMD_DES, dsmc_pkg::DSMC_CMD_NOP: begin
      end
      dsmc_pkg::DSMC_CMD_MRS: begin
        next_mod_cnt = MOD_CYC;
        if (mr_sel == `DSMC_MR_SEL_0) begin
          next_bl_mode = ADDR[`DSMC_MODE0_BL_HI:`DSMC_MODE0_BL_LO];
        end else if (mr_sel == `DSMC_MR_SEL_3) begin
          next_fgr_mode = ADDR[`DSMC_MODE3_FGR_HI:`DSMC_MODE3_FGR_LO];
          if (ADDR[`DSMC_MODE3_PAGE_HI:`DSMC_MODE3_PAGE_LO] == 2'h0) begin
            next_pat_en = ADDR[`DSMC_MODE3_PAT_EN];
          end else if (ADDR[`DSMC_MODE3_PAT_EN]) begin
            next_reject = 1'b1;
          end
        end else if (mr_sel == `DSMC_MR_SEL_4 && ADDR[`DSMC_MODE4_DPD]) begin
          next_pwr     = dsmc_pkg::DSMC_PWR_ENTERING;
          next_pwr_cnt = 8'h01;
        end
      end
      default: begin
        if (mod_cnt != 8'h00) begin
          next_reject = 1'b1;
        end else if (cmd == dsmc_pkg::DSMC_CMD_REF && !CKE) begin
          next_self_ref = 1'b1;
        end else if (cmd == dsmc_pkg::DSMC_CMD_REF && pat_en
                     && fgr_mode != `DSMC_FGR_FIXED_1X) begin
          next_reject = 1'b1;
        end else if (pat_en && cmd == dsmc_pkg::DSMC_CMD_WR) begin
          store_bus.wr_en = 1'b1;
        end else if (pat_en && cmd == dsmc_pkg::DSMC_CMD_RD) begin
          store_bus.rd_en = 1'b1;
          next_rd_valid   = 1'b1;
          next_rd_chop    = (bl_mode == `DSMC_BL_CHOP);
        end else begin
          next_array_valid = 1'b1;
        end
      end
    endcase

    unique case (gear)
      dsmc_pkg::DSMC_GEAR_1N: begin
        if (cmd == dsmc_pkg::DSMC_CMD_MRS && mr_sel == `DSMC_MR_SEL_3
            && ADDR[`DSMC_MODE3_GEAR]) begin
          next_gear     = dsmc_pkg::DSMC_GEAR_WAIT_SYNC;
          next_gear_cnt = 8'h01;
        end
      end
      dsmc_pkg::DSMC_GEAR_WAIT_SYNC: begin
        // Sync pulse counts only an even number of clocks after the MRS.
        if (cmd == dsmc_pkg::DSMC_CMD_NOP && !gear_cnt[0]) begin
          next_gear      = dsmc_pkg::DSMC_GEAR_SETTLE;
          next_phase_ref = phase;
          next_gear_cnt  = 8'h01;
        end
      end
      dsmc_pkg::DSMC_GEAR_SETTLE: begin
        if (gear_cnt >= GEAR_CYC) begin
          next_gear = dsmc_pkg::DSMC_GEAR_2N;
        end
      end
      dsmc_pkg::DSMC_GEAR_2N: begin
        if (cmd == dsmc_pkg::DSMC_CMD_MRS && mr_sel == `DSMC_MR_SEL_3
            && !ADDR[`DSMC_MODE3_GEAR]) begin
          next_gear = dsmc_pkg::DSMC_GEAR_1N;
        end
      end
    endcase

    if (self_ref && CKE) begin
      next_self_ref = 1'b0;
      next_gear     = dsmc_pkg::DSMC_GEAR_1N;
    end

    unique case (pwr)
      dsmc_pkg::DSMC_PWR_ACTIVE: begin
      end
      dsmc_pkg::DSMC_PWR_ENTERING: begin
        if (pwr_cnt >= ENTRY_CYC) begin
          next_pwr = dsmc_pkg::DSMC_PWR_DEEP;
        end
      end
      default: begin
        if (!cke_q && CKE && !CS_N) begin
          next_pwr = dsmc_pkg::DSMC_PWR_ACTIVE;
        end
      end
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RST || !RESET_N) begin
      gear            <= dsmc_pkg::DSMC_GEAR_1N;
      pwr             <= dsmc_pkg::DSMC_PWR_ACTIVE;
      pat_en          <= 1'b0;
      bl_mode         <= `DSMC_BL_RESET;
      fgr_mode        <= `DSMC_FGR_RESET;
      self_ref        <= 1'b0;
      phase           <= 1'b0;
      phase_ref       <= 1'b0;
      cke_q           <= 1'b0;
      mod_cnt         <= 8'h00;
      gear_cnt        <= 8'h00;
      pwr_cnt         <= 8'h00;
      ARRAY_CMD_VALID <= 1'b0;
      ARRAY_CMD       <= 4'h0;
      CMD_REJECT      <= 1'b0;
      RD_VALID        <= 1'b0;
      RD_CHOP         <= 1'b0;
    end else begin
      gear            <= next_gear;
      pwr             <= next_pwr;
      pat_en          <= next_pat_en;
      bl_mode         <= next_bl_mode;
      fgr_mode        <= next_fgr_mode;
      self_ref        <= next_self_ref;
      phase           <= next_phase;
      phase_ref       <= next_phase_ref;
      cke_q           <= next_cke_q;
      mod_cnt         <= next_mod_cnt;
      gear_cnt        <= next_gear_cnt;
      pwr_cnt         <= next_pwr_cnt;
      ARRAY_CMD_VALID <= next_array_valid;
      ARRAY_CMD       <= next_array_cmd;
      CMD_REJECT      <= next_reject;
      RD_VALID        <= next_rd_valid;
      RD_CHOP         <= next_rd_chop;
    end
  end

  assign RD_DATA         = store_bus.rd_data;
  assign PATTERN_MODE    = pat_en;
  assign GEAR_DOWN       = (gear == dsmc_pkg::DSMC_GEAR_2N);
  assign SELF_REFRESH    = self_ref;
  assign DEEP_POWER_DOWN = (pwr == dsmc_pkg::DSMC_PWR_DEEP);
  assign INPUTS_ENABLED  = (pwr != dsmc_pkg::DSMC_PWR_DEEP);
endmodule
`default_nettype wire

// *** verilog/dsmc_regs.svh ***
// Purpose: Field positions, select codes, reset values and timing counts.
// Assumes: Command clock of 200 MHz; times are in nanoseconds.
// Notes:   Cycle counts round least times up to whole clocks.
`ifndef DSMC_REGS_SVH
`define DSMC_REGS_SVH

`define DSMC_CLK_PERIOD_PS  5000
`define DSMC_MR_SEL_0       3'h0
`define DSMC_MR_SEL_3       3'h3
`define DSMC_MR_SEL_4       3'h4
`define DSMC_MODE0_BL_HI    1
`define DSMC_MODE0_BL_LO    0
`define DSMC_BL_CHOP        2'h2
`define DSMC_MODE3_PAGE_HI  1
`define DSMC_MODE3_PAGE_LO  0
`define DSMC_MODE3_PAT_EN   2
`define DSMC_MODE3_GEAR     3
`define DSMC_MODE3_FGR_HI   8
`define DSMC_MODE3_FGR_LO   6
`define DSMC_MODE4_DPD      1
`define DSMC_BL_RESET       2'h0
`define DSMC_FGR_RESET      3'h0
`define DSMC_FGR_FIXED_1X   3'h0
`define DSMC_PATTERN_RESET  32'h00000000
`define DSMC_T_MOD_NS       60
`define DSMC_T_DPD_ENTRY_NS 100
`define DSMC_T_GEAR_CMD_NS  40
`define DSMC_NS_TO_CYC(t)   (((t) * 1000 + `DSMC_CLK_PERIOD_PS - 1) / `DSMC_CLK_PERIOD_PS)
`define DSMC_MOD_CYC        `DSMC_NS_TO_CYC(`DSMC_T_MOD_NS)
`define DSMC_DPD_ENTRY_CYC  `DSMC_NS_TO_CYC(`DSMC_T_DPD_ENTRY_NS)
`define DSMC_GEAR_CMD_CYC   `DSMC_NS_TO_CYC(`DSMC_T_GEAR_CMD_NS)

`endif

// *** verilog/dsmc_pkg.sv ***
// Purpose: Types shared by the special-mode command logic.
// Assumes: Nothing beyond the constants header.
// Notes:   Commands are decoded values, not pin codes.
package dsmc_pkg;
  typedef enum logic [3:0] {
    DSMC_CMD_DES, DSMC_CMD_NOP, DSMC_CMD_ACT, DSMC_CMD_MRS, DSMC_CMD_REF,
    DSMC_CMD_PRE, DSMC_CMD_WR, DSMC_CMD_RD, DSMC_CMD_ZQ
  } dsmc_cmd_t;
  typedef enum logic [1:0] {DSMC_GEAR_1N, DSMC_GEAR_WAIT_SYNC, DSMC_GEAR_SETTLE, DSMC_GEAR_2N}
    dsmc_gear_t;
  typedef enum logic [1:0] {DSMC_PWR_ACTIVE, DSMC_PWR_ENTERING, DSMC_PWR_DEEP} dsmc_pwr_t;
endpackage

// *** verilog/dsmc_store_if.sv ***
// Purpose: Carries pattern store accesses between the control and the store.
// Assumes: One clock shared by both ends.
// Notes:   Read data appear one clock after rd_en.
`timescale 1ns/1ps
`default_nettype none
interface dsmc_store_if;
  logic       wr_en;
  logic [1:0] wr_loc;
  logic [7:0] wr_data;
  logic       rd_en;
  logic [1:0] rd_loc;
  logic       rd_chop;
  logic [7:0] rd_data;
  modport client (output wr_en, wr_loc, wr_data, rd_en, rd_loc, rd_chop, input rd_data);
  modport store  (input wr_en, wr_loc, wr_data, rd_en, rd_loc, rd_chop, output rd_data);
endinterface
`default_nettype wire

// *** verilog/dsmc_pattern_store.sv ***
// Purpose: Four 8-bit pattern locations with a registered read port.
// Assumes: Accesses come from the command control on the same clock.
// Notes:   Kept apart from the array so pattern writes never touch it.
`timescale 1ns/1ps
`default_nettype none
`include "dsmc_regs.svh"
module dsmc_pattern_store #(
  parameter logic [31:0] PATTERN_INIT = `DSMC_PATTERN_RESET
) (
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   rst,
  // Access port
  dsmc_store_if.store port
);
  logic [3:0][7:0] mem;
  logic [3:0][7:0] next_mem;
  logic [7:0]      rd_data;
  logic [7:0]      next_rd_data;

  always_comb begin
    next_mem     = mem;
    next_rd_data = rd_data;
    if (port.wr_en) begin
      next_mem[port.wr_loc] = port.wr_data;
    end
    if (port.rd_en) begin
      // Beats four to seven of a chopped burst are driven as zero.
      next_rd_data = port.rd_chop ? {4'h0, mem[port.rd_loc][3:0]} : mem[port.rd_loc];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mem     <= PATTERN_INIT;
      rd_data <= 8'h00;
    end else begin
      mem     <= next_mem;
      rd_data <= next_rd_data;
    end
  end

  assign port.rd_data = rd_data;
endmodule
`default_nettype wire

// *** verif/dsmc_top_chk.sv ***
// Purpose: Port checks for the special-mode command block.
// Assumes: One clock; RST high or RESET_N low resets the block.
// Notes:   Bound into every dsmc_top.
`timescale 1ns/1ps
`default_nettype none
module dsmc_top_chk (
  // Clock and reset
  input wire logic       CLOCK,
  input wire logic       RST,
  input wire logic       RESET_N,
  // Command pins
  input wire logic       CKE,
  input wire logic       CS_N,
  input wire logic       ACT_N,
  input wire logic       RAS_N,
  input wire logic       CAS_N,
  input wire logic       WE_N,
  // Results
  input wire logic       PATTERN_MODE,
  input wire logic       GEAR_DOWN,
  input wire logic       DEEP_POWER_DOWN,
  input wire logic       ARRAY_CMD_VALID,
  input wire logic       RD_VALID,
  input wire logic       RD_CHOP,
  input wire logic [7:0] RD_DATA
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST || !RESET_N);
  wire       sel = !CS_N && ACT_N;
  wire [2:0] op  = {RAS_N, CAS_N, WE_N};
  sequence s_wake;
    DEEP_POWER_DOWN && $rose(CKE);
  endsequence
  sequence s_pat_wr;
    PATTERN_MODE && sel && op == 3'h4;
  endsequence
  a_reset_in_1n: assert property ($fell(RST) |-> !GEAR_DOWN && !PATTERN_MODE)
    else $error("mode bits set after reset");
  a_read_cause: assert property (RD_VALID |-> $past(PATTERN_MODE && sel && op == 3'h5))
    else $error("read data without a pattern read");
  a_chop_upper: assert property (RD_VALID && RD_CHOP |-> RD_DATA[7:4] == 4'h0)
    else $error("chopped burst carries upper beats");
  a_write_private: assert property (s_pat_wr |=> !ARRAY_CMD_VALID)
    else $error("pattern write reached the array");
  a_gear_sync: assert property ($rose(GEAR_DOWN) |-> $past(sel && op == 3'h7, 9))
    else $error("2N began without a sync nine edges back");
  a_deep_quiet: assert property (DEEP_POWER_DOWN && $past(DEEP_POWER_DOWN)
    |-> !ARRAY_CMD_VALID && !RD_VALID)
    else $error("command answered in deep power-down");
  a_wake_hold: assert property (s_wake ##0 CS_N |=> DEEP_POWER_DOWN [*2])
    else $error("left deep power-down with chip select high");
  a_wake_exit: assert property (s_wake ##0 !CS_N |-> ##[1:2] !DEEP_POWER_DOWN)
    else $error("deep power-down exit missed");
endmodule
bind dsmc_top dsmc_top_chk chk_u (
  .CLOCK(CLOCK), .RST(RST), .RESET_N(RESET_N), .CKE(CKE), .CS_N(CS_N), .ACT_N(ACT_N),
  .RAS_N(RAS_N), .CAS_N(CAS_N), .WE_N(WE_N), .PATTERN_MODE(PATTERN_MODE),
  .GEAR_DOWN(GEAR_DOWN), .DEEP_POWER_DOWN(DEEP_POWER_DOWN), .ARRAY_CMD_VALID(ARRAY_CMD_VALID),
  .RD_VALID(RD_VALID), .RD_CHOP(RD_CHOP), .RD_DATA(RD_DATA)
);
`default_nettype wire

// *** verif/dsmc_ctrl_model.sv ***
// Purpose: Memory controller model that drives the command pins.
// Assumes: Pins change only at the falling clock edge.
// Notes:   Waits between commands come from the calling sequence.
`timescale 1ns/1ps
`default_nettype none
module dsmc_ctrl_model (
  // Clock
  input  wire logic        clk,
  // Command and address pins
  output var  logic        cke,
  output var  logic        cs_n,
  output var  logic [3:0]  op_n,
  output var  logic [1:0]  bg,
  output var  logic [1:0]  ba,
  output var  logic [17:0] addr
);
  logic cke_next = 1'b1;
  initial begin
    cke = 1'b1;
    cs_n = 1'b1;
    op_n = 4'hf;
    bg = 2'h0;
    ba = 2'h0;
    addr = 18'h0;
  end
  // One command for one clock; reads carry A12 high so on-the-fly bursts stay legal.
  task automatic issue(input logic [3:0] c, input logic [1:0] g, input logic [1:0] b,
                       input logic [17:0] a);
    @(negedge clk);
    cke = cke_next;
    cs_n = 1'b0;
    op_n = c;
    bg = g;
    ba = b;
    addr = (c == 4'hd) ? (a | 18'h01000) : a;
  endtask
  // Deselect; the idle bus toggles so a stale value is never mistaken for a command.
  task automatic des(input int n);
    repeat (n) begin
      @(negedge clk);
      cke = cke_next;
      cs_n = 1'b1;
      addr = ~addr;
      bg = ~bg;
      ba = ~ba;
    end
  endtask
endmodule
`default_nettype wire

// *** verif/test_dsmc_top.sv ***
// Purpose: Scenario bench for the special-mode command block.
// Assumes: Inputs change at the falling clock edge.
// Notes:   Mode-set waits are 13 idle clocks, past the 12-clock hold.
`timescale 1ns/1ps
`default_nettype none
module test_dsmc_top;
  logic             clk = 1'b0;
  logic             rst = 1'b1;
  logic             rst_n = 1'b1;
  wire logic        cke, cs_n, pm, gd, sr, dpd, ien, av, rej, rv, rc;
  wire logic [3:0]  op_n, acmd;
  wire logic [1:0]  bg, ba;
  wire logic [17:0] addr;
  wire logic [7:0]  rdat;
  int               miscompares = 0;
  int               compares = 0;

  always #2.5 clk = ~clk;

  dsmc_ctrl_model ctl_u (.clk(clk), .cke(cke), .cs_n(cs_n), .op_n(op_n), .bg(bg), .ba(ba),
                         .addr(addr));
  dsmc_top dut_u (
    .CLOCK(clk), .RST(rst), .RESET_N(rst_n), .CKE(cke), .CS_N(cs_n), .ACT_N(op_n[3]),
    .RAS_N(op_n[2]), .CAS_N(op_n[1]), .WE_N(op_n[0]), .BG(bg), .BA(ba), .ADDR(addr),
    .PATTERN_MODE(pm), .GEAR_DOWN(gd), .SELF_REFRESH(sr), .DEEP_POWER_DOWN(dpd),
    .INPUTS_ENABLED(ien), .ARRAY_CMD_VALID(av), .ARRAY_CMD(acmd), .CMD_REJECT(rej),
    .RD_VALID(rv), .RD_CHOP(rc), .RD_DATA(rdat)
  );

  task automatic chk_flag(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Deselects at the next falling edge and looks there, while the one-cycle answer stands.
  task automatic look();
    ctl_u.des(1);
  endtask
  task automatic mrs(input logic [2:0] s, input logic [17:0] a);
    ctl_u.issue(4'h8, {1'b0, s[2]}, s[1:0], a);
  endtask
  task automatic cmd(input logic [3:0] c, input logic exp);
    ctl_u.issue(c, 2'h0, 2'h0, 18'h0);
    look();
    chk_flag(av, exp);
  endtask
  task automatic wake(input logic cs_low, input logic exp);
    ctl_u.cke_next = 1'b0;
    ctl_u.des(2);
    ctl_u.cke_next = 1'b1;
    if (cs_low) begin
      ctl_u.issue(4'hf, 2'h0, 2'h0, 18'h0);
    end else begin
      ctl_u.des(1);
    end
    look();
    look();
    chk_flag(dpd, exp);
  endtask

  task automatic test_pattern();
    logic [7:0] pat [4] = '{8'h5a, 8'h3c, 8'h81, 8'he7};
    mrs(3'h3, 18'h00006);
    look();
    chk_flag(rej, 1'b1);
    chk_flag(pm, 1'b0);
    mrs(3'h3, 18'h00004);
    ctl_u.des(13);
    chk_flag(pm, 1'b1);
    for (int i = 0; i < 4; i++) begin
      ctl_u.issue(4'hc, 2'h3, i[1:0], {10'h3ff, pat[i]});
      look();
      chk_flag(av, 1'b0);
    end
    for (int i = 0; i < 4; i++) begin
      ctl_u.issue(4'hd, 2'h2, i[1:0], 18'h00400);
      look();
      chk_flag(rv, 1'b1);
      chk_flag(rc, 1'b0);
      chk_data(rdat, pat[i]);
    end
    mrs(3'h0, 18'h00002);
    ctl_u.des(13);
    ctl_u.issue(4'hd, 2'h0, 2'h1, 18'h0);
    look();
    chk_flag(rv, 1'b1);
    chk_flag(rc, 1'b1);
    chk_data(rdat, {4'h0, pat[1][3:0]});
    mrs(3'h3, 18'h00044);
    ctl_u.des(13);
    ctl_u.issue(4'h9, 2'h0, 2'h0, 18'h0);
    look();
    chk_flag(rej, 1'b1);
    mrs(3'h3, 18'h00004);
    ctl_u.des(13);
    cmd(4'h9, 1'b1);
    chk_data({4'h0, acmd}, {4'h0, dsmc_pkg::DSMC_CMD_REF});
    ctl_u.des(1);
    mrs(3'h3, 18'h0);
    ctl_u.issue(4'h7, 2'h0, 2'h0, 18'h0);
    look();
    chk_flag(rej, 1'b1);
    chk_flag(pm, 1'b0);
    ctl_u.des(10);
    cmd(4'h7, 1'b1);
    chk_data({4'h0, acmd}, {4'h0, dsmc_pkg::DSMC_CMD_ACT});
    $display("pattern test done");
  endtask

  task automatic test_gear();
    mrs(3'h3, 18'h00008);
    ctl_u.issue(4'hf, 2'h0, 2'h0, 18'h0);
    ctl_u.issue(4'hf, 2'h0, 2'h0, 18'h0);
    ctl_u.des(7);
    look();
    chk_flag(gd, 1'b0);
    look();
    chk_flag(gd, 1'b1);
    ctl_u.des(2);
    cmd(4'h7, 1'b1);
    ctl_u.des(1);
    cmd(4'h7, 1'b0);
    ctl_u.des(1);
    ctl_u.cke_next = 1'b0;
    cmd(4'h9, 1'b0);
    chk_flag(sr, 1'b1);
    ctl_u.cke_next = 1'b1;
    ctl_u.des(2);
    look();
    chk_flag(sr, 1'b0);
    chk_flag(gd, 1'b0);
    $display("gear test done");
  endtask

  task automatic test_deep();
    mrs(3'h4, 18'h00002);
    ctl_u.des(19);
    look();
    chk_flag(dpd, 1'b0);
    look();
    chk_flag(dpd, 1'b1);
    chk_flag(ien, 1'b0);
    cmd(4'h7, 1'b0);
    wake(1'b0, 1'b1);
    wake(1'b1, 1'b0);
    chk_flag(ien, 1'b1);
    $display("deep power-down test done");
  endtask

  task automatic test_reset_pin();
    mrs(3'h3, 18'h00004);
    ctl_u.des(13);
    chk_flag(pm, 1'b1);
    rst_n = 1'b0;
    ctl_u.des(2);
    rst_n = 1'b1;
    chk_flag(pm, 1'b0);
    chk_flag(gd, 1'b0);
    chk_data(rdat, 8'h00);
    mrs(3'h3, 18'h00004);
    ctl_u.des(13);
    ctl_u.issue(4'hd, 2'h0, 2'h2, 18'h0);
    look();
    chk_flag(rv, 1'b1);
    chk_data(rdat, 8'h00);
    $display("reset pin test done");
  endtask

  task automatic print_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #20000;
    miscompares++;
    print_verdict();
  end

  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    @(posedge clk);
    #1;
    chk_flag(gd, 1'b0);
    chk_flag(pm, 1'b0);
    $display("reset test done");
    test_pattern();
    test_gear();
    test_deep();
    test_reset_pin();
    print_verdict();
  end
endmodule
`default_nettype wire
